/* rtl/sdct_map.svh */
// Timing figures, command codes and field positions for the SDRAM command link.
// Assumes a single system clock; the controller turns the spacing figures into cycles with the package helpers.
`ifndef SDCT_MAP_SVH
`define SDCT_MAP_SVH
`define SDCT_CLK_PS        25000
`define SDCT_T_RC_PS       72000
`define SDCT_T_RAS_MIN_PS  48000
`define SDCT_T_RAS_MAX_PS  100000000
`define SDCT_T_RCD_PS      20000
`define SDCT_T_RP_PS       20000
`define SDCT_T_RRD_PS      16000
`define SDCT_T_WR_CL2_PS   10000
`define SDCT_T_WR_CL3_PS   8000
`define SDCT_T_MRD_PS      16000
`define SDCT_T_CK_CL2_PS   10000
`define SDCT_T_CK_CL3_PS   8000
`define SDCT_T_CK_MAX_PS   1000000
`define SDCT_T_PWRUP_PS    200000000
`define SDCT_INIT_REFS     8
`define SDCT_RD_DQM_LAT    2
`define SDCT_CMD_MRS       4'h0
`define SDCT_CMD_REF       4'h1
`define SDCT_CMD_PRE       4'h2
`define SDCT_CMD_ACT       4'h3
`define SDCT_CMD_WR        4'h4
`define SDCT_CMD_RD        4'h5
`define SDCT_CMD_BST       4'h6
`define SDCT_CMD_NOP       4'h7
`define SDCT_AP_BIT        10
`define SDCT_MR_BL_LSB     0
`define SDCT_MR_CL_LSB     4
`define SDCT_BL_FULL       3'h7
`define SDCT_FULL_PAGE     9'h100
`endif

/* rtl/sdct_pkg.sv */
// Types and shared helpers for both ends of the SDRAM command link.
// Assumes sdct_map.svh is reachable on the include path.
`include "sdct_map.svh"
package sdct_pkg;
    typedef logic [3:0] sdct_cmd_t;
    typedef enum {H_PWR, H_PALL, H_MRS, H_REF, H_IDLE, H_RW} sdct_hstate_e;

    // A least time rounds up to whole cycles and never below one.
    function automatic int sdct_cyc_min(input int t_ps, input int clk_ps);
        int c;
        c = (t_ps + clk_ps - 1) / clk_ps;
        return (c < 1) ? 1 : c;
    endfunction

    // A longest time rounds down and never below one.
    function automatic int sdct_cyc_max(input int t_ps, input int clk_ps);
        int c;
        c = t_ps / clk_ps;
        return (c < 1) ? 1 : c;
    endfunction
endpackage

/* rtl/sdct_if.sv */
// Pin-level SDRAM link between the controller end and the memory end.
// Resolves the shared data pins from both enables; an undriven byte reads as zero.
`timescale 1ns/1ps
interface sdct_if;
    logic        cke;
    logic        cs_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic [1:0]  ba;
    logic [10:0] addr;
    logic [3:0]  dqm;
    logic [31:0] h_dq;
    logic        h_dq_oe;
    logic [31:0] d_dq;
    logic [3:0]  d_dq_oe;
    logic [31:0] dq;

    always_comb
    begin
        for (int b = 0; b < 4; b++)
        begin
            if (h_dq_oe)
                dq[b*8 +: 8] = h_dq[b*8 +: 8];
            else if (d_dq_oe[b])
                dq[b*8 +: 8] = d_dq[b*8 +: 8];
            else
                dq[b*8 +: 8] = 8'h00;
        end
    end

    modport host (output cke, cs_n, ras_n, cas_n, we_n, ba, addr, dqm, h_dq, h_dq_oe,
                  input dq);
    modport dev  (input cke, cs_n, ras_n, cas_n, we_n, ba, addr, dqm, dq,
                  output d_dq, d_dq_oe);
endinterface

/* rtl/sdct_timer.sv */
// Down-counter that marks when a minimum command spacing has run out.
// Assumes load and count share the caller's clock and clock enable.
`timescale 1ns/1ps
module sdct_timer #(
    parameter int W = 16
) (
    input  wire logic         clk_i,
    input  wire logic         rst_b_i,
    input  wire logic         ce_i,
    input  wire logic         load_i,
    input  wire logic [W-1:0] load_val_i,
    output logic              done_o
);
    import sdct_pkg::*;
    logic [W-1:0] cnt;

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            cnt <= '0;
        else if (ce_i)
        begin
            if (load_i)
                cnt <= load_val_i;
            else if (cnt != '0)
                cnt <= cnt - 1'b1;
        end
    end

    assign done_o = (cnt == '0);
endmodule

/* rtl/sdct_host.sv */
// Controller end: power-up sequence, then single-word accesses with auto-precharge.
// Assumes the memory end sits on the same clock, so its data needs no synchroniser.
`timescale 1ns/1ps
`include "sdct_map.svh"
module sdct_host #(
    parameter int CAS_LAT    = 2,
    parameter int CLK_PS     = `SDCT_CLK_PS,
    parameter int PWR_UP_CYC = `SDCT_T_PWRUP_PS / `SDCT_CLK_PS
) (
    input  wire logic        CLK_SYS_I,
    input  wire logic        RST_B_I,
    input  wire logic        CE_I,
    input  wire logic        REQ_I,
    input  wire logic        REQ_WE_I,
    input  wire logic [1:0]  REQ_BANK_I,
    input  wire logic [10:0] REQ_ROW_I,
    input  wire logic [7:0]  REQ_COL_I,
    input  wire logic [31:0] REQ_WDATA_I,
    input  wire logic [3:0]  REQ_BE_I,
    input  wire logic        REF_REQ_I,
    output logic             REQ_READY_O,
    output logic [31:0]      RDATA_O,
    output logic             RDATA_VALID_O,
    output logic             INIT_DONE_O,
    sdct_if.host             sd
);
    import sdct_pkg::*;

    localparam int TW = 16;
    localparam int RC_CYC  = sdct_cyc_min(`SDCT_T_RC_PS, CLK_PS);
    localparam int RAS_CYC = sdct_cyc_min(`SDCT_T_RAS_MIN_PS, CLK_PS);
    localparam int RAS_MAX = sdct_cyc_max(`SDCT_T_RAS_MAX_PS, CLK_PS);
    localparam int RCD_CYC = sdct_cyc_min(`SDCT_T_RCD_PS, CLK_PS);
    localparam int RP_CYC  = sdct_cyc_min(`SDCT_T_RP_PS, CLK_PS);
    localparam int RRD_CYC = sdct_cyc_min(`SDCT_T_RRD_PS, CLK_PS);
    localparam int WR_CYC  = sdct_cyc_min((CAS_LAT == 2) ? `SDCT_T_WR_CL2_PS
                                                         : `SDCT_T_WR_CL3_PS, CLK_PS);
    localparam int MRD_CYC = sdct_cyc_min(`SDCT_T_MRD_PS, CLK_PS);
    localparam int BURST   = 1;
    // The column wait covers both the column delay and the least open time, because
    // auto-precharge starts right after the single-word burst.
    localparam int ACT_RW  = (RCD_CYC > RAS_CYC) ? RCD_CYC : RAS_CYC;
    // Accesses go to one bank at a time, so the bank-to-bank spacing folds into this.
    localparam int ACT_GAP = (ACT_RW > RRD_CYC) ? ACT_RW : RRD_CYC;
    localparam int RD_END  = BURST + RP_CYC;
    localparam int WR_END  = BURST + WR_CYC + RP_CYC;

    if (CAS_LAT != 2 && CAS_LAT != 3)
        $error("CAS_LAT must be 2 or 3");
    if ((CAS_LAT == 2 && CLK_PS < `SDCT_T_CK_CL2_PS) ||
        (CAS_LAT == 3 && CLK_PS < `SDCT_T_CK_CL3_PS) || CLK_PS > `SDCT_T_CK_MAX_PS)
        $error("clock period does not suit the CAS latency");
    if (PWR_UP_CYC < 1 || PWR_UP_CYC >= (1 << 20))
        $error("PWR_UP_CYC out of range");
    if (RC_CYC >= (1 << TW) || ACT_GAP + 1 >= RAS_MAX)
        $error("timing counts do not fit the timers");

    sdct_hstate_e state;
    logic [19:0]  pwr_cnt;
    logic [3:0]   ref_cnt;
    logic         gap_done;
    logic         rc_done;
    logic         gap_load;
    logic         rc_load;
    logic [TW-1:0] gap_val;
    logic         req_we;
    logic [1:0]   req_bank;
    logic [7:0]   req_col;
    logic [31:0]  req_wdata;
    logic [3:0]   req_be;
    logic [2:0]   rd_pipe;
    sdct_cmd_t    cmd;
    logic         idle_free;

    sdct_timer #(.W(TW)) u_gap (
        .clk_i      (CLK_SYS_I),
        .rst_b_i    (RST_B_I),
        .ce_i       (CE_I),
        .load_i     (gap_load),
        .load_val_i (gap_val),
        .done_o     (gap_done)
    );

    sdct_timer #(.W(TW)) u_rc (
        .clk_i      (CLK_SYS_I),
        .rst_b_i    (RST_B_I),
        .ce_i       (CE_I),
        .load_i     (rc_load),
        .load_val_i (TW'(RC_CYC)),
        .done_o     (rc_done)
    );

    assign idle_free   = (state == H_IDLE) && gap_done && rc_done;
    assign REQ_READY_O = idle_free && !REF_REQ_I;
    assign INIT_DONE_O = (state == H_IDLE);

    // Decide what issues this cycle; anything not chosen stays NOP.
    always_comb
    begin
        cmd      = `SDCT_CMD_NOP;
        gap_load = 1'b0;
        rc_load  = 1'b0;
        gap_val  = '0;
        case (state)
            H_PALL:
                if (gap_done)
                begin
                    cmd      = `SDCT_CMD_PRE;
                    gap_load = 1'b1;
                    gap_val  = TW'(RP_CYC);
                end
            H_MRS:
                if (gap_done)
                begin
                    cmd      = `SDCT_CMD_MRS;
                    gap_load = 1'b1;
                    gap_val  = TW'(MRD_CYC);
                end
            H_REF:
                if (gap_done && rc_done)
                begin
                    cmd     = `SDCT_CMD_REF;
                    rc_load = 1'b1;
                end
            H_IDLE:
                if (idle_free && REF_REQ_I)
                begin
                    cmd     = `SDCT_CMD_REF;
                    rc_load = 1'b1;
                end
                else if (idle_free && REQ_I)
                begin
                    cmd      = `SDCT_CMD_ACT;
                    rc_load  = 1'b1;
                    gap_load = 1'b1;
                    gap_val  = TW'(ACT_GAP);
                end
            H_RW:
                if (gap_done)
                begin
                    cmd      = req_we ? `SDCT_CMD_WR : `SDCT_CMD_RD;
                    gap_load = 1'b1;
                    // Auto-precharge recovery, with write recovery on writes.
                    gap_val  = req_we ? TW'(WR_END) : TW'(RD_END);
                end
            default:
                cmd = `SDCT_CMD_NOP;
        endcase
    end

    always_ff @(posedge CLK_SYS_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            state   <= H_PWR;
            pwr_cnt <= 20'(PWR_UP_CYC);
            ref_cnt <= 4'h0;
        end
        else if (CE_I)
        begin
            case (state)
                H_PWR:
                begin
                    pwr_cnt <= pwr_cnt - 1'b1;
                    if (pwr_cnt == 20'h00001)
                        state <= H_PALL;
                end
                H_PALL:
                    if (gap_done)
                        state <= H_MRS;
                H_MRS:
                    if (gap_done)
                        state <= H_REF;
                H_REF:
                    if (gap_done && rc_done)
                    begin
                        ref_cnt <= ref_cnt + 1'b1;
                        if (ref_cnt == 4'(`SDCT_INIT_REFS - 1))
                            state <= H_IDLE;
                    end
                H_IDLE:
                    if (REQ_READY_O && REQ_I)
                        state <= H_RW;
                H_RW:
                    if (gap_done)
                        state <= H_IDLE;
                default:
                    state <= H_PWR;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            req_we    <= 1'b0;
            req_bank  <= 2'h0;
            req_col   <= 8'h00;
            req_wdata <= 32'h0;
            req_be    <= 4'h0;
        end
        else if (CE_I && REQ_READY_O && REQ_I)
        begin
            req_we    <= REQ_WE_I;
            req_bank  <= REQ_BANK_I;
            req_col   <= REQ_COL_I;
            req_wdata <= REQ_WDATA_I;
            req_be    <= REQ_BE_I;
        end
    end

    // Pins come from flops; masks and clock enable stay high through power-up.
    always_ff @(posedge CLK_SYS_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            sd.cke     <= 1'b1;
            {sd.cs_n, sd.ras_n, sd.cas_n, sd.we_n} <= `SDCT_CMD_NOP;
            sd.ba      <= 2'h0;
            sd.addr    <= 11'h000;
            sd.dqm     <= 4'hF;
            sd.h_dq    <= 32'h0;
            sd.h_dq_oe <= 1'b0;
        end
        else if (CE_I)
        begin
            sd.cke     <= 1'b1;
            {sd.cs_n, sd.ras_n, sd.cas_n, sd.we_n} <= cmd;
            sd.h_dq_oe <= 1'b0;
            sd.addr    <= 11'h000;
            sd.dqm     <= (state == H_PWR) ? 4'hF : 4'h0;
            case (cmd)
                `SDCT_CMD_PRE:
                    sd.addr[`SDCT_AP_BIT] <= 1'b1;
                `SDCT_CMD_MRS:
                begin
                    sd.addr[`SDCT_MR_BL_LSB +: 3] <= 3'h0;
                    sd.addr[`SDCT_MR_CL_LSB +: 3] <= 3'(CAS_LAT);
                end
                `SDCT_CMD_ACT:
                begin
                    sd.ba   <= REQ_BANK_I;
                    sd.addr <= REQ_ROW_I;
                end
                `SDCT_CMD_RD,
                `SDCT_CMD_WR:
                begin
                    sd.ba                 <= req_bank;
                    sd.addr[7:0]          <= req_col;
                    sd.addr[`SDCT_AP_BIT] <= 1'b1;
                    sd.h_dq               <= req_wdata;
                    sd.h_dq_oe            <= req_we;
                    // At CAS latency two byte enables mask reads as well, so an unwanted read byte floats.
                    sd.dqm                <= ~req_be;
                end
                default:
                    sd.ba <= sd.ba;
            endcase
        end
    end

    // Read data is taken CAS latency cycles after the read appears on the pins.
    always_ff @(posedge CLK_SYS_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            rd_pipe       <= 3'h0;
            RDATA_O       <= 32'h0;
            RDATA_VALID_O <= 1'b0;
        end
        else if (CE_I)
        begin
            rd_pipe       <= {rd_pipe[1:0], {sd.cs_n, sd.ras_n, sd.cas_n, sd.we_n} ==
                                            `SDCT_CMD_RD};
            RDATA_VALID_O <= rd_pipe[CAS_LAT-1];
            if (rd_pipe[CAS_LAT-1])
                RDATA_O <= sd.dq;
        end
    end
endmodule

/* rtl/sdct_dev.sv */
// Memory end: decodes pin commands and serves bursts from a small internal array.
// Assumes the controller keeps all spacing minimums; none are checked here.
`timescale 1ns/1ps
`include "sdct_map.svh"
module sdct_dev #(
    parameter int ROW_W = 3,
    parameter int COL_W = 4
) (
    input  wire logic        CLK_SYS_I,
    input  wire logic        RST_B_I,
    input  wire logic        CE_I,
    output logic [3:0]       BANK_OPEN_O,
    output logic             BURST_BUSY_O,
    output logic [1:0]       CAS_LAT_O,
    sdct_if.dev              sd
);
    import sdct_pkg::*;

    // Only the low row and column bits are stored, which keeps the array small.
    localparam int AW = 2 + ROW_W + COL_W;
    if (ROW_W < 1 || ROW_W > 11 || COL_W < 1 || COL_W > 8)
        $error("array widths out of range");

    logic [31:0]      mem [2**AW];
    logic             cke_q;
    logic             en;
    sdct_cmd_t        cmd;
    logic [1:0]       cl;
    logic [2:0]       bl_code;
    logic [ROW_W-1:0] open_row [4];
    logic [8:0]       brst_left;
    logic [1:0]       brst_bank;
    logic [7:0]       brst_col;
    logic             brst_rd;
    logic             brst_ap;
    logic             stop;
    logic             issue;
    logic             start;
    logic [1:0]       cur_bank;
    logic [7:0]       cur_col;
    logic [2:0]       pv;
    logic [31:0]      pd [3];
    logic [3:0]       dqm_d1;
    logic [3:0]       dqm_d2;
    logic [8:0]       bl_len;

    function automatic logic [AW-1:0] word_idx(input logic [1:0] b,
                                               input logic [ROW_W-1:0] r,
                                               input logic [7:0] c);
        return {b, r, c[COL_W-1:0]};
    endfunction

    // The clock enable pin is sampled, then suspends the next cycle onward.
    always_ff @(posedge CLK_SYS_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
            cke_q <= 1'b1;
        else if (CE_I)
            cke_q <= sd.cke;
    end
    assign en = CE_I && cke_q;

    // Select low takes the command in the same cycle.
    assign cmd   = sd.cs_n ? `SDCT_CMD_NOP : {1'b0, sd.ras_n, sd.cas_n, sd.we_n};
    assign start = (cmd == `SDCT_CMD_RD) || (cmd == `SDCT_CMD_WR);
    assign stop  = (cmd == `SDCT_CMD_BST) ||
                   ((cmd == `SDCT_CMD_PRE) && (sd.addr[`SDCT_AP_BIT] || sd.ba == brst_bank));
    assign bl_len = (bl_code == `SDCT_BL_FULL) ? `SDCT_FULL_PAGE : 9'(1 << bl_code);
    // A terminating command issues no word in its own cycle, so the last word shows
    // one cycle before the float.
    assign issue    = start || ((brst_left != 9'h0) && !stop);
    assign cur_bank = start ? sd.ba : brst_bank;
    assign cur_col  = start ? sd.addr[7:0] : brst_col;

    always_ff @(posedge CLK_SYS_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            cl          <= 2'h2;
            bl_code     <= 3'h0;
            BANK_OPEN_O <= 4'h0;
            brst_left   <= 9'h0;
            brst_bank   <= 2'h0;
            brst_col    <= 8'h00;
            brst_rd     <= 1'b0;
            brst_ap     <= 1'b0;
            for (int b = 0; b < 4; b++)
                open_row[b] <= '0;
        end
        else if (en)
        begin
            if (cmd == `SDCT_CMD_MRS)
            begin
                bl_code <= sd.addr[`SDCT_MR_BL_LSB +: 3];
                cl      <= (sd.addr[`SDCT_MR_CL_LSB +: 3] == 3'h3) ? 2'h3 : 2'h2;
            end
            if (cmd == `SDCT_CMD_ACT)
            begin
                BANK_OPEN_O[sd.ba] <= 1'b1;
                open_row[sd.ba]    <= sd.addr[ROW_W-1:0];
            end
            if (cmd == `SDCT_CMD_PRE)
            begin
                if (sd.addr[`SDCT_AP_BIT])
                    BANK_OPEN_O <= 4'h0;
                else
                    BANK_OPEN_O[sd.ba] <= 1'b0;
            end
            if (start)
            begin
                brst_left <= bl_len - 1'b1;
                brst_bank <= sd.ba;
                brst_col  <= sd.addr[7:0] + 1'b1;
                brst_rd   <= (cmd == `SDCT_CMD_RD);
                brst_ap   <= sd.addr[`SDCT_AP_BIT];
                if (bl_len == 9'h1 && sd.addr[`SDCT_AP_BIT])
                    BANK_OPEN_O[sd.ba] <= 1'b0;
            end
            else if (stop)
                brst_left <= 9'h0;
            else if (brst_left != 9'h0)
            begin
                brst_left <= brst_left - 1'b1;
                brst_col  <= brst_col + 1'b1;
                if (brst_left == 9'h1 && brst_ap)
                    BANK_OPEN_O[brst_bank] <= 1'b0;
            end
        end
    end

    // Write words are taken in the cycle they arrive, first one with the command,
    // and a masked byte is left untouched.
    always_ff @(posedge CLK_SYS_I)
    begin
        if (en && issue && (start ? (cmd == `SDCT_CMD_WR) : !brst_rd))
        begin
            for (int b = 0; b < 4; b++)
                if (!sd.dqm[b])
                    mem[word_idx(cur_bank, open_row[cur_bank], cur_col)][b*8 +: 8]
                        <= sd.dq[b*8 +: 8];
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            pv     <= 3'h0;
            dqm_d1 <= 4'hF;
            dqm_d2 <= 4'hF;
            for (int s = 0; s < 3; s++)
                pd[s] <= 32'h0;
        end
        else if (en)
        begin
            pv     <= {pv[1:0], issue && (start ? (cmd == `SDCT_CMD_RD) : brst_rd)};
            pd[0]  <= mem[word_idx(cur_bank, open_row[cur_bank], cur_col)];
            pd[1]  <= pd[0];
            pd[2]  <= pd[1];
            dqm_d1 <= sd.dqm;
            dqm_d2 <= dqm_d1;
        end
    end

    // Output byte floats two cycles after its mask is sampled.
    assign sd.d_dq    = pd[cl-1];
    assign sd.d_dq_oe = {4{pv[cl-1]}} & ~dqm_d2;
    assign BURST_BUSY_O = (brst_left != 9'h0);
    assign CAS_LAT_O    = cl;
endmodule

/* verif/sdct_link_monitor.sv */
// Checker on the pin link between the controller end and the memory end.
// Assumes CAS latency two, one-word auto-precharge bursts and a 25 ns clock.
`timescale 1ns/1ps
`include "sdct_map.svh"
module sdct_link_monitor #(
    parameter int PWR_UP_CYC = 8000
) (
    input wire logic        CLK_SYS_I,
    input wire logic        RST_B_I,
    input wire logic        CE_I,
    input wire logic        cke,
    input wire logic        cs_n,
    input wire logic        ras_n,
    input wire logic        cas_n,
    input wire logic        we_n,
    input wire logic [10:0] addr,
    input wire logic [3:0]  dqm,
    input wire logic        h_dq_oe,
    input wire logic [3:0]  d_dq_oe
);
    logic [3:0]  cmd;
    logic        act, rfr, rd, wr, pre;
    logic        pre_seen;
    logic [3:0]  ref_cnt;
    logic [15:0] up_cnt;

    default clocking cb @(posedge CLK_SYS_I); endclocking
    // A frozen cycle is no cycle of the link, so the checks are disabled, and any attempt in flight is dropped, while the enable is low.
    default disable iff (!RST_B_I || !CE_I);

    assign cmd = {cs_n, ras_n, cas_n, we_n};
    assign act = (cmd == `SDCT_CMD_ACT);
    assign rfr = (cmd == `SDCT_CMD_REF);
    assign rd  = (cmd == `SDCT_CMD_RD);
    assign wr  = (cmd == `SDCT_CMD_WR);
    assign pre = (cmd == `SDCT_CMD_PRE);

    always_ff @(posedge CLK_SYS_I or negedge RST_B_I)
        if (!RST_B_I) pre_seen <= 1'b0;
        else if (CE_I && pre && addr[`SDCT_AP_BIT]) pre_seen <= 1'b1;

    always_ff @(posedge CLK_SYS_I or negedge RST_B_I)
        if (!RST_B_I) ref_cnt <= 4'h0;
        else if (CE_I && rfr && ref_cnt != 4'hF) ref_cnt <= ref_cnt + 4'h1;

    // Counts the quiet cycles before the first precharge, saturating.
    always_ff @(posedge CLK_SYS_I or negedge RST_B_I)
        if (!RST_B_I) up_cnt <= 16'h0;
        else if (CE_I && !pre_seen && up_cnt != 16'hFFFF) up_cnt <= up_cnt + 16'h1;

    chk_row_cycle_gap: assert property ((act || rfr) |=> (!(act || rfr)) [*2])
        else $error("activate or refresh spaced too closely");
    chk_act_to_col: assert property (act |=> !(rd || wr))
        else $error("column command too soon after activate");
    chk_ap_recovery: assert property (
        (rd || wr) |-> addr[`SDCT_AP_BIT] ##1 !(act || rfr))
        else $error("auto-precharge recovery not kept");
    chk_mode_after_pre: assert property ((cmd == `SDCT_CMD_MRS) |-> pre_seen)
        else $error("mode set before precharge all");
    chk_refs_before_use: assert property ((act || rd || wr) |-> ref_cnt >= 4'h8)
        else $error("access before eight refreshes");
    chk_pwrup_quiet: assert property (
        (!pre_seen && !pre) |-> cke && dqm == 4'hF && cmd == `SDCT_CMD_NOP)
        else $error("link not quiet during power-up pause");
    chk_pwrup_wait: assert property (
        (pre && !pre_seen) |-> up_cnt >= 16'(PWR_UP_CYC - 1))
        else $error("power-up pause too short");
    chk_rd_mask_float: assert property (
        rd |-> ##2 (d_dq_oe == ~$past(dqm, 2)) ##1 (d_dq_oe == 4'h0))
        else $error("read word or float at wrong cycle");
    chk_wr_data_with_cmd: assert property (wr |-> h_dq_oe && d_dq_oe == 4'h0)
        else $error("write data not with write command");
    chk_dev_drive_cause: assert property ((d_dq_oe != 4'h0) |-> $past(rd, 2))
        else $error("memory drives data without a read");

    cover property (act ##2 rd);
    cover property (wr && h_dq_oe);
    cover property (rfr);
endmodule

/* verif/testbench.sv */
// Self-checking bench: both ends joined by the link, user side of the controller driven here.
// Assumes a shortened power-up pause; inputs change on the falling clock edge.
`timescale 1ns/1ps
module testbench;
    localparam int PWR = 20;
    logic        clk = 1'b0, rst_b = 1'b0, ce = 1'b1, req = 1'b0, we = 1'b0, ref_req = 1'b0;
    logic [1:0]  bank = 2'h0;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  be = 4'hF;
    logic        ready, rvalid, init_done;
    logic [31:0] rdata;
    logic [1:0]  cas_lat;
    logic [3:0]  bank_open;
    logic        busy;
    int          num_errors = 0;
    int          samples_checked = 0;

    sdct_if sd();
    always #12.5 clk = ~clk;

    sdct_host #(.PWR_UP_CYC(PWR)) i_sdct_host (.CLK_SYS_I(clk), .RST_B_I(rst_b), .CE_I(ce),
        .REQ_I(req), .REQ_WE_I(we), .REQ_BANK_I(bank), .REQ_ROW_I(11'h005), .REQ_COL_I(8'h0A),
        .REQ_WDATA_I(wdata), .REQ_BE_I(be), .REF_REQ_I(ref_req), .REQ_READY_O(ready),
        .RDATA_O(rdata), .RDATA_VALID_O(rvalid), .INIT_DONE_O(init_done), .sd(sd));
    sdct_dev i_sdct_dev (.CLK_SYS_I(clk), .RST_B_I(rst_b), .CE_I(ce), .BANK_OPEN_O(bank_open),
        .BURST_BUSY_O(busy), .CAS_LAT_O(cas_lat), .sd(sd));
    sdct_link_monitor #(.PWR_UP_CYC(PWR)) i_sdct_link_monitor (.CLK_SYS_I(clk), .RST_B_I(rst_b),
        .cke(sd.cke), .cs_n(sd.cs_n), .ras_n(sd.ras_n), .cas_n(sd.cas_n), .we_n(sd.we_n),
        .addr(sd.addr), .dqm(sd.dqm), .h_dq_oe(sd.h_dq_oe), .d_dq_oe(sd.d_dq_oe), .CE_I(ce));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test;
        $display("Checks %0d, mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Holds the request until ready is seen, so it is taken at the next rising edge.
    task automatic take(input logic w, input logic [1:0] b, input logic [31:0] d,
                        input logic [3:0] e);
        int n;
        @(negedge clk);
        req = 1'b1; we = w; bank = b; wdata = d; be = e;
        for (n = 0; ready !== 1'b1 && n < 100; n++)
            @(negedge clk);
        check(32'(ready), 32'h1);
        @(negedge clk);
        req = 1'b0;
    endtask

    // Freezing both ends right after the take must delay the word by exactly that span.
    task automatic do_read(input logic [1:0] b, input logic [3:0] e, input logic [31:0] exp,
                           input int hold);
        int n;
        take(1'b0, b, 32'h0, e);
        n = 0;
        if (hold > 0) ce = 1'b0;
        repeat (hold) begin @(negedge clk); n++; end
        ce = 1'b1;
        while (rvalid !== 1'b1 && n < 30) begin @(negedge clk); n++; end
        check(32'(n), 32'(6 + hold));
        check(rdata, exp);
        // Auto-precharge has closed the bank by the time the word is back.
        check(32'({busy, bank_open}), 32'h0);
    endtask

    task automatic sc_banks;
        for (int b = 0; b < 4; b++)
            take(1'b1, 2'(b), 32'hA5C3_0000 | 32'(b), 4'hF);
        for (int b = 0; b < 4; b++)
            do_read(2'(b), 4'hF, 32'hA5C3_0000 | 32'(b), 0);
    endtask

    task automatic sc_mask;
        take(1'b1, 2'h1, 32'h1122_3344, 4'h5);
        do_read(2'h1, 4'hF, 32'hA522_0044, 0);
        do_read(2'h1, 4'h3, 32'h0000_0044, 0);
    endtask

    task automatic sc_refresh;
        @(negedge clk);
        ref_req = 1'b1;
        @(negedge clk);
        check(32'(ready), 32'h0);
        repeat (8) @(negedge clk);
        ref_req = 1'b0;
        do_read(2'h2, 4'hF, 32'hA5C3_0002, 0);
    endtask

    initial
    begin
        #(5000 * 25);
        num_errors++;
        end_of_test();
    end

    initial
    begin
        repeat (6) @(negedge clk);
        rst_b = 1'b1;
        repeat (300) if (init_done !== 1'b1) @(negedge clk);
        check(32'(init_done), 32'h1);
        check(32'(cas_lat), 32'h2);
        sc_banks();
        sc_mask();
        sc_refresh();
        do_read(2'h3, 4'hF, 32'hA5C3_0003, 2);
        end_of_test();
    end
endmodule
